// File: baud_tick_divider.sv
// Divides the kernel clock into the oversampling tick.
// Assumes the period is two or more and stable while enabled.
`timescale 1ns/1ps
`default_nettype none
module baud_tick_divider
   import uart_baud_pkg::*;
#(
   parameter int W = DIV_W + 1
)(
   // Clock and reset
   input  wire logic         ref_clk,
   input  wire logic         rst,
   // Control
   input  wire logic         restart,
   input  wire logic         enable,
   input  wire logic [W-1:0] period,
   // One-cycle enable pulse
   output var  logic         tick
);
   typedef struct packed {
      logic [W-1:0] cnt;
      logic         tick;
   } div_t;
   div_t state_r;   // Registered state
   div_t state_nxt; // Next state

   // Restart aligns the ticks to the start of each bit
   always_comb begin
      state_nxt = state_r;
      state_nxt.tick = 1'b0;
      if (restart) begin
         state_nxt.cnt = '0;
      end else if (enable) begin
         if (state_r.cnt >= period - W'(1)) begin
            state_nxt.cnt = '0;
            state_nxt.tick = 1'b1;
         end else begin
            state_nxt.cnt = state_r.cnt + W'(1);
         end
      end
   end

   // State register
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         state_r <= '0;
      end else begin
         state_r <= state_nxt;
      end
   end

   assign tick = state_r.tick;
endmodule
`default_nettype wire

// File: bit_timer.sv
// Times one serial bit in kernel clock cycles.
// Assumes the length is at least one cycle and stable with load.
`timescale 1ns/1ps
`default_nettype none
module bit_timer
   import uart_baud_pkg::*;
#(
   parameter int LW = LEN_W
)(
   // Clock and reset
   input  wire logic          ref_clk,
   input  wire logic          rst,
   // Bit request
   input  wire logic          load,
   input  wire logic [LW-1:0] len,
   // Bit events
   output var  logic          done,
   output var  logic          busy
);
   // Timer states
   typedef enum logic [0:0] {T_IDLE = 1'b0, T_RUN = 1'b1} tstate_t;
   typedef struct packed {
      tstate_t        st;
      logic [LW-1:0]  cnt;
      logic           done;
   } timer_t;
   timer_t state_r;   // Registered state
   timer_t state_nxt; // Next state

   // Count down; a new load restarts even a running bit
   always_comb begin
      state_nxt = state_r;
      state_nxt.done = 1'b0;
      case (state_r.st)
         T_IDLE: begin
            if (load) begin
               state_nxt.cnt = len;
               state_nxt.st = T_RUN;
            end
         end
         T_RUN: begin
            if (load) begin
               state_nxt.cnt = len;
            end else if (state_r.cnt <= LW'(1)) begin
               state_nxt.done = 1'b1;
               state_nxt.st = T_IDLE;
            end else begin
               state_nxt.cnt = state_r.cnt - LW'(1);
            end
         end
         default: state_nxt.st = T_IDLE;
      endcase
   end

   // State register
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         state_r <= '0;
      end else begin
         state_r <= state_nxt;
      end
   end

   assign done = state_r.done;
   assign busy = (state_r.st == T_RUN);
endmodule
`default_nettype wire

// File: serial_peer.sv
// Model of the remote serial end that asks the generator to time bits.
// Assumes the generator pulses bitDone once for each timed bit.
`timescale 1ns/1ps
`default_nettype none
module serial_peer
   import uart_baud_pkg::*;
(
   // Clock and reset
   input  wire logic        ref_clk,
   input  wire logic        rst,
   // Bench control
   input  wire logic        go,
   input  wire bitKind_t    kind,
   input  wire logic [7:0]  gap,
   // Generator side
   output var  bitReq_t     bitReq,
   input  wire logic        bitDone,
   // Measured bit length in kernel cycles
   output var  logic        lenValid,
   output var  logic [21:0] lenVal
);
   logic [7:0]  waitCnt; // Idle cycles before the load, a slow peer
   logic [21:0] cnt;     // Edges since the load was taken
   logic        pend;    // Load still to be issued
   logic        run;     // Bit in flight

   // One bit per go; its length is the span from load to bitDone
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         bitReq   <= '0;
         waitCnt  <= 8'h00;
         cnt      <= 22'h0;
         pend     <= 1'b0;
         run      <= 1'b0;
         lenValid <= 1'b0;
         lenVal   <= 22'h0;
      end else begin
         bitReq.load <= 1'b0;
         lenValid    <= 1'b0;
         cnt         <= cnt + 22'h1;
         if (go) begin
            pend        <= 1'b1;
            waitCnt     <= gap;
            bitReq.kind <= kind;
         end else if (pend && waitCnt != 8'h00) begin
            waitCnt <= waitCnt - 8'h01;
         end else if (pend) begin
            pend        <= 1'b0;
            bitReq.load <= 1'b1;
         end
         // bitDone lands one edge after the bit ends, hence the minus one
         if (bitReq.load) begin
            run <= 1'b1;
            cnt <= 22'h1;
         end else if (run && bitDone) begin
            run      <= 1'b0;
            lenValid <= 1'b1;
            lenVal   <= cnt - 22'h1;
         end
      end
   end
endmodule
`default_nettype wire

// File: tb_top.sv
// Self-checking bench for the baud generator and its registers.
// Assumes uart_baud_gen and serial_peer compiled before it.
`timescale 1ns/1ps
`default_nettype none
module tb_top
   import uart_baud_pkg::*;
;
   logic        ref_clk;     // Kernel clock, 125 MHz
   logic        rst;         // Async reset, active high
   avReq_t      avReq;       // Bus request
   logic [31:0] readdata;    // Bus read data
   logic        waitrequest; // Bus stall
   logic        bitBusy;     // Bit being timed
   logic        sampleTick;  // Oversampling tick
   logic [21:0] eLen;        // Length under check
   int          busyCnt;     // Busy cycles this bit
   int          ticks;       // Ticks this bit
   logic [31:0] expTick[$];  // Expected tick counts
   bitReq_t     bitReq;      // From peer
   logic        bitDone;     // Bit period ended
   logic        abDone;      // Auto-baud finished
   logic [15:0] abDivisor;   // Auto-baud result
   funcMode_t   funcMode;    // Function select
   baudMode_t   baudMode;    // Divider mode
   logic        go;          // Start one bit in the peer
   bitKind_t    kind;        // Kind of that bit
   logic [7:0]  gap;         // Peer delay before load
   logic        lenValid;    // Length measured
   logic [21:0] lenVal;      // Measured length
   int          mismatches;
   int          total_checks;
   logic [31:0] expRd[$];    // Expected read data, oldest first
   logic [21:0] expLen[$];   // Expected bit lengths, oldest first

   // Floor of one suits a low-speed crystal kernel clock
   uart_baud_gen #(.MIN_DIV_DIRECT(16'h0001)) dut (
      .ref_clk(ref_clk), .rst(rst), .avReq(avReq), .readdata(readdata),
      .waitrequest(waitrequest), .bitReq(bitReq), .bitDone(bitDone),
      .bitBusy(bitBusy), .sampleTick(sampleTick), .abDone(abDone),
      .abDivisor(abDivisor), .funcMode(funcMode), .baudMode(baudMode));

   serial_peer peer (
      .ref_clk(ref_clk), .rst(rst), .go(go), .kind(kind), .gap(gap),
      .bitReq(bitReq), .bitDone(bitDone), .lenValid(lenValid),
      .lenVal(lenVal));

   // Clock generator
   always #4 ref_clk = ~ref_clk;

   task automatic cmp32(input logic [31:0] e, input logic [31:0] a);
      total_checks++;
      if (a !== e) begin
         mismatches++;
         $display("FAIL t=%0t exp=%h got=%h", $time, e, a);
      end
   endtask

   task automatic cmp22(input logic [21:0] e, input logic [21:0] a);
      cmp32({10'h0, e}, {10'h0, a});
   endtask

   // Watcher: pair each answer with the oldest expectation
   always @(posedge ref_clk) begin
      if (avReq.read && waitrequest === 1'b0 && expRd.size() > 0) begin
         cmp32(expRd.pop_front(), readdata);
      end
      if (lenValid === 1'b1 && expLen.size() > 0) begin
         eLen = expLen.pop_front();
         cmp22(eLen, lenVal);
         cmp22(eLen, 22'(busyCnt));
         cmp32(expTick.pop_front(), 32'(ticks));
      end
      // Busy cycles and ticks since the last load
      if (bitReq.load) begin
         busyCnt = 0;
         ticks   = 0;
      end else begin
         busyCnt += (bitBusy === 1'b1) ? 1 : 0;
         ticks   += (sampleTick === 1'b1) ? 1 : 0;
      end
   end

   // Hold the request until waitrequest is seen low, then release
   task automatic bus_xfer(input logic w, input logic [3:0] a,
                           input logic [31:0] d);
      int n;
      avReq.read      <= ~w;
      avReq.write     <= w;
      avReq.address   <= a;
      avReq.writedata <= d;
      avReq.byteenable <= 4'hf;
      n = 0;
      do begin
         @(posedge ref_clk);
         n++;
      end while (waitrequest !== 1'b0 && n < 100);
      if (n >= 100) mismatches++;
      avReq.read  <= 1'b0;
      avReq.write <= 1'b0;
      @(posedge ref_clk);
   endtask

   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      bus_xfer(1'b1, a, d);
   endtask

   task automatic rd(input logic [3:0] a, input logic [31:0] e);
      expRd.push_back(e);
      bus_xfer(1'b0, a, 32'h0);
   endtask

   // Ask the peer for one bit and wait for its measurement
   task automatic bit_len(input bitKind_t k, input int e, input int t);
      int n;
      expLen.push_back(22'(e));
      expTick.push_back(32'(t));
      go   <= 1'b1;
      kind <= k;
      gap  <= 8'($urandom_range(0, 3));
      @(posedge ref_clk);
      go <= 1'b0;
      n = 0;
      do begin
         @(posedge ref_clk);
         n++;
      end while (lenValid !== 1'b1 && n < 5000);
      if (n >= 5000) mismatches++;
      @(posedge ref_clk);
   endtask

   // Run all eleven bit kinds under one mask and sign in mode 2
   task automatic comp_run(input int d, input logic [8:0] m,
                           input logic s);
      int e;
      wr(OFF_BAUD, {4'h3, 12'h0, 16'(d)});
      wr(OFF_COMP, {s, 22'h0, m});
      for (int k = 0; k <= 10; k++) begin
         e = d + 2;
         if (k >= 1 && k <= 9 && m[k-1]) e = s ? e - 1 : e + 1;
         bit_len(bitKind_t'(k[3:0]), e, e / (d + 2));
      end
      rd(OFF_BAUD, {4'h3, 12'h0, 16'(d)});
      rd(OFF_COMP, {s, 22'h0, m});
   endtask

   task automatic final_report();
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   // Watchdog well beyond the expected run length
   initial begin
      repeat (60000) @(posedge ref_clk);
      mismatches++;
      final_report();
   end

   // Main sequence
   initial begin
      int d;
      int e;
      int p;
      logic [15:0] ab;
      ref_clk = 1'b0;
      rst = 1'b1;
      avReq = '0;
      abDone = 1'b0;
      abDivisor = 16'h0000;
      go = 1'b0;
      kind = BIT_START;
      gap = 8'h00;
      mismatches = 0;
      total_checks = 0;
      void'($urandom(32'h5ff6));
      repeat (10) @(posedge ref_clk);
      rst <= 1'b0;
      @(posedge ref_clk);
      rd(OFF_BAUD, BAUD_RST);
      rd(OFF_COMP, COMP_RST);
      rd(OFF_FUNC, {30'h0, FUNC_RST});
      cmp32({30'h0, MODE_X16}, {30'h0, baudMode});
      $display("test reset done");
      // Unmapped place: write ignored, read gives zero
      wr(4'h2, $urandom);
      rd(4'h2, 32'h0);
      rd(OFF_BAUD, BAUD_RST);
      for (int f = 0; f < 4; f++) begin
         wr(OFF_FUNC, 32'(f));
         rd(OFF_FUNC, 32'(f));
         cmp32(32'(f), {30'h0, funcMode});
      end
      $display("test function select done");
      // Every mode code, start bit then stop bit, random divisors
      for (int m = 0; m < 4; m++) begin
         for (int r = 0; r < 2; r++) begin
            // Nine or more meets 3N-1 for N up to three
            d = (m == 3) ? $urandom_range(9, 40) : $urandom_range(0, 3);
            e = $urandom_range(8, 15);
            p = (m < 2) ? 16 : (m == 2) ? e + 1 : 1;
            wr(OFF_BAUD, {2'b00, 2'(m), 4'(e), 8'h0, 16'(d)});
            rd(OFF_BAUD, {2'b00, 2'(m), 4'(e), 8'h0, 16'(d)});
            cmp32(32'(m), {30'h0, baudMode});
            bit_len(bitKind_t'(10*r), p*(d+2), p);
         end
      end
      $display("test divider modes done");
      comp_run(1, 9'h0a5, 1'b0);
      comp_run(5, 9'h082, 1'b1);
      comp_run($urandom_range(2, 9), 9'($urandom), 1'b1);
      comp_run(1, 9'h100, 1'b1);
      // Divisor below its floor is flagged in status, not enforced
      wr(OFF_BAUD, 32'h3000_0000);
      rd(OFF_STAT, {24'h0, BIT_STOP, 4'h2});
      $display("test compensation done");
      // Auto-baud result replaces divisor and forces mode 2
      wr(OFF_BAUD, 32'h2a00_0005);
      ab = 16'($urandom_range(0, 20));
      abDone <= 1'b1;
      abDivisor <= ab;
      @(posedge ref_clk);
      abDone <= 1'b0;
      @(posedge ref_clk);
      cmp32({30'h0, MODE_DIRECT}, {30'h0, baudMode});
      rd(OFF_BAUD, {8'h3a, 8'h00, ab});
      bit_len(BIT_START, 32'(ab) + 2, 1);
      $display("test auto-baud done");
      final_report();
   end
endmodule
`default_nettype wire

// File: uart_baud_gen.sv
// Baud rate generator with per-bit compensation and its registers.
// Assumes one kernel clock and an Avalon-MM master with waitrequest.
//
// What this block does
// R1 - Software selects UART, IrDA, LIN or RS-485
// R2 - Kernel clock divided into bit clock
// R3 - Mode field 29:28 selects divider mode
// R4 - Software keeps mode 0 under IrDA
// R5 - Mode 0: sixteen times divisor plus two
// R6 - Mode 1: extra divider; software keeps it >=8
// R7 - Mode 2: divisor plus two; floor nine
// R8 - Fast kernel clock needs divisor 3N-1
// R9 - Low-speed crystal allows divisor one
// R10 - Sign zero lengthens compensated bit
// R11 - Sign one shortens compensated bit
// R12 - Nine mask bits: data 7:0, parity
// R13 - Auto-baud result loads divisor field
// R14 - Auto-baud completion forces mode 2
// R15 - Start, stop uncompensated; divisor untouched
//
// Decided for this implementation: the Avalon-MM interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module uart_baud_gen
   import uart_baud_pkg::*;
#(
   // Mode-2 divisor floor; one for a low-speed crystal  [R9]
   parameter logic [15:0] MIN_DIV_DIRECT = DIV_MIN_M2
)(
   // Clock and reset
   input  wire logic        ref_clk,
   input  wire logic        rst,
   // Avalon-MM slave
   input  wire avReq_t      avReq,
   output var  logic [31:0] readdata,
   output var  logic        waitrequest,
   // Bit timing requests from the shifters
   input  wire bitReq_t     bitReq,
   output var  logic        bitDone,
   output var  logic        bitBusy,
   output var  logic        sampleTick,
   // Auto-baud measurement result
   input  wire logic        abDone,
   input  wire logic [15:0] abDivisor,
   // Selected modes
   output var  funcMode_t   funcMode,
   output var  baudMode_t   baudMode
);
   // Registered state of the block, bar the bit timer and tick divider
   typedef struct packed {
      logic [31:0] baud;     // Divider register
      logic [31:0] comp;     // Compensation register
      funcMode_t   func;     // Function select
      logic        waitReq;  // Bus wait state
      logic [31:0] rdata;    // Captured read data
      logic        limitErr; // Divisor or extra divider below its floor
      logic        irdaErr;  // IrDA without mode 0
      bitKind_t    kind;     // Kind of the last bit
   } state_t;

   state_t            state_r;    // Registered state
   state_t            state_nxt;  // Next state
   logic              reqValid;   // Read or write pending
   logic              accept;     // Request completes this edge
   logic [31:0]       wrMerged;   // Write data merged by lanes
   logic [31:0]       statusWord; // Status register image
   logic [31:0]       readMux;    // Addressed register value
   logic [15:0]       baud_divisor;        // Baud divisor field
   logic [3:0]        edm;        // Extra divider field
   baudMode_t         modeNow;    // Current divider mode
   logic [MASK_W-1:0] maskBits;   // Compensation mask
   logic              signBit;    // Compensation sign
   logic [4:0]        presc;      // Oversampling ticks per bit
   logic [LEN_W-1:0]  baseLen;    // Uncompensated bit length
   logic [LEN_W-1:0]  tLen;       // Bit length sent to timer
   logic [MASK_W-1:0] compHit;    // Mask bit hit per bit kind
   logic              compAny;    // This bit is compensated
   logic [16:0]       tickPeriod; // Divisor plus two

   // Byte-lane merge for partial writes
   function automatic logic [31:0] mergeBytes(
      input logic [31:0] oldVal,
      input logic [31:0] newVal,
      input logic [3:0]  be
   );
      logic [31:0] m;
      m = oldVal;
      for (int b = 0; b < 4; b++) begin
         if (be[b]) begin
            m[8*b +: 8] = newVal[8*b +: 8];
         end
      end
      return m;
   endfunction

   // Field views of the registers
   assign baud_divisor      = state_r.baud[DIV_LSB +: DIV_W];
   assign edm      = state_r.baud[EDIV_LSB +: EDIV_W];
   assign modeNow  = baudMode_t'(state_r.baud[MODE_LSB +: 2]);
   assign maskBits = state_r.comp[MASK_W-1:0];
   assign signBit  = state_r.comp[SIGN_BIT];

   // Oversampling ticks per bit for each mode
   always_comb begin
      case (modeNow)
         MODE_EXTRA:  presc = {1'b0, edm} + 5'h01;   // [R6] [R3]
         MODE_DIRECT: presc = PRESC_ONE;            // [R7] [R3]
         default:     presc = PRESC_X16;            // [R5] [R3]
      endcase
   end

   // Divisor plus two sets the tick; presc ticks make one bit
   assign tickPeriod = {1'b0, baud_divisor} + DIV_OFFSET;
   assign baseLen    = LEN_W'(presc) * LEN_W'(tickPeriod); // [R2]

   // One mask bit per data bit and parity; start and stop have none
   for (genvar i = 0; i < MASK_W; i++) begin : g_comp
      assign compHit[i] = maskBits[i] &&
         (bitReq.kind == 4'(int'(BIT_D0) + i));     // [R12] [R15]
   end
   assign compAny = |compHit;

   // Compensation moves one kernel cycle; the divisor stays as is
   always_comb begin
      if (!compAny) begin
         tLen = baseLen;                            // [R15]
      end else if (signBit) begin
         tLen = baseLen - LEN_W'(1);                // [R11]
      end else begin
         tLen = baseLen + LEN_W'(1);                // [R10]
      end
   end

   // Status image: own checks, busy and the bit being timed
   always_comb begin
      statusWord = '0;
      statusWord[ST_IRDA]       = state_r.irdaErr;
      statusWord[ST_LIMIT]      = state_r.limitErr;
      statusWord[ST_BUSY]       = bitBusy;
      statusWord[ST_KIND +: 4]  = state_r.kind;
   end

   // Read decode; unmapped offsets read as zero
   always_comb begin
      case (avReq.address)
         OFF_BAUD: readMux = state_r.baud;
         OFF_COMP: readMux = state_r.comp;
         OFF_FUNC: readMux = {30'h0, state_r.func};
         OFF_STAT: readMux = statusWord;
         default:  readMux = 32'h0000_0000;
      endcase
   end

   // One wait cycle, then the request completes
   assign reqValid = avReq.read | avReq.write;
   assign accept   = reqValid && !state_r.waitReq;
   assign wrMerged = mergeBytes(readMux, avReq.writedata,
                                avReq.byteenable);

   // Next-state logic for registers, bus and checks
   always_comb begin
      state_nxt = state_r;
      // Waitrequest drops for exactly one cycle per request
      state_nxt.waitReq = !(reqValid && state_r.waitReq);
      // Read data are captured during the wait cycle
      if (avReq.read && state_r.waitReq) begin
         state_nxt.rdata = readMux;
      end
      // Writes land at the edge that ends the request
      if (accept && avReq.write) begin
         case (avReq.address)
            OFF_BAUD: state_nxt.baud = wrMerged;
            OFF_COMP: state_nxt.comp = wrMerged;
            OFF_FUNC: state_nxt.func =
               funcMode_t'(wrMerged[FUNC_W-1:0]);   // [R1]
            default:  state_nxt.baud = state_r.baud; // Ignored
         endcase
      end
      // Auto-baud result wins over a software write that edge
      if (abDone) begin
         state_nxt.baud[DIV_LSB +: DIV_W] = abDivisor;   // [R13]
         state_nxt.baud[MODE_LSB +: 2]   = 2'b11;        // [R14]
      end
      // Floors that software must honour; flagged, not enforced
      state_nxt.limitErr =
         ((modeNow == MODE_EXTRA) && (edm < EDIV_MIN)) ||    // [R6]
         ((modeNow == MODE_DIRECT) &&
          (baud_divisor < MIN_DIV_DIRECT));                      // [R7] [R8]
      // IrDA timing only works from the x16 divider
      state_nxt.irdaErr = (state_r.func == FUNC_IRDA) &&
                          (modeNow != MODE_X16);         // [R4]
      // Remember which bit is being timed
      if (bitReq.load) begin
         state_nxt.kind = bitReq.kind;
      end
   end

   // State register; reset gives mode 0, divisor 0, UART function
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         state_r <= '{baud: BAUD_RST, comp: COMP_RST,
                      func: funcMode_t'(FUNC_RST), waitReq: 1'b1,
                      rdata: 32'h0000_0000, limitErr: 1'b0,
                      irdaErr: 1'b0, kind: BIT_START};
      end else begin
         state_r <= state_nxt;
      end
   end

   // Bit length counter, restarted by every bit request
   bit_timer #(
      .LW (LEN_W)
   ) u_bitTimer (
      .ref_clk (ref_clk),
      .rst     (rst),
      .load    (bitReq.load),
      .len     (tLen),
      .done    (bitDone),
      .busy    (bitBusy)
   );

   // Oversampling tick, aligned to each bit start
   baud_tick_divider #(
      .W (DIV_W + 1)
   ) u_tickDiv (
      .ref_clk (ref_clk),
      .rst     (rst),
      .restart (bitReq.load),
      .enable  (bitBusy),
      .period  (tickPeriod),
      .tick    (sampleTick)
   );

   // Outputs straight from registers
   assign readdata    = state_r.rdata;
   assign waitrequest = state_r.waitReq;
   assign funcMode    = state_r.func;
   assign baudMode    = modeNow;

   // A completed function select write shows on the mode output
   property p_funcSel;
      @(posedge ref_clk) disable iff (rst)
      (avReq.write && !waitrequest && avReq.address == OFF_FUNC &&
       avReq.byteenable[0])
      |=> (funcMode == $past(avReq.writedata[1:0]));
   endproperty
   a_funcSel: assert property (p_funcSel) // [R1]
      else $error("function select write not applied");

   // A two-cycle bit ends exactly three edges after its load
   property p_bitPeriod;
      @(posedge ref_clk) disable iff (rst)
      (bitReq.load && tLen == 22'd2) ##1 (!bitReq.load) [*2]
      |=> bitDone;
   endproperty
   a_bitPeriod: assert property (p_bitPeriod) // [R2]
      else $error("bit done not on time");

   // Mode 0 start bit lasts sixteen ticks of divisor plus two
   property p_mode0Len;
      @(posedge ref_clk) disable iff (rst)
      (bitReq.load && baudMode == MODE_X16 && bitReq.kind == BIT_START)
      |-> (tLen == 22'd16 * ({6'd0, baud_divisor} + 22'd2));
   endproperty
   a_mode0Len: assert property (p_mode0Len) // [R5]
      else $error("mode 0 bit length wrong");

   // Mode 1 stop bit uses the extra divider plus one
   property p_mode1Len;
      @(posedge ref_clk) disable iff (rst)
      (bitReq.load && baudMode == MODE_EXTRA && bitReq.kind == BIT_STOP)
      |-> (tLen == ({18'd0, edm} + 22'd1) * ({6'd0, baud_divisor} + 22'd2));
   endproperty
   a_mode1Len: assert property (p_mode1Len) // [R6]
      else $error("mode 1 bit length wrong");

   // Mode 2 divides directly; low divisor raises the flag next edge
   property p_mode2Limit;
      @(posedge ref_clk) disable iff (rst)
      (baudMode == MODE_DIRECT && baud_divisor < MIN_DIV_DIRECT && !abDone)
      ##1 $stable(state_r.baud) |-> state_r.limitErr;
   endproperty
   a_mode2Limit: assert property (p_mode2Limit) // [R7]
      else $error("mode 2 divisor floor not flagged");

   // Positive compensation adds one cycle to a masked data bit
   property p_lengthen;
      @(posedge ref_clk) disable iff (rst)
      (bitReq.load && baudMode == MODE_DIRECT &&
       bitReq.kind == BIT_D0 && maskBits[0] && !signBit)
      |-> (tLen == {6'd0, baud_divisor} + 22'd3);
   endproperty
   a_lengthen: assert property (p_lengthen) // [R10]
      else $error("compensated bit not lengthened");

   // Negative compensation removes one cycle
   property p_shorten;
      @(posedge ref_clk) disable iff (rst)
      (bitReq.load && baudMode == MODE_DIRECT &&
       bitReq.kind == BIT_D7 && maskBits[7] && signBit)
      |-> (tLen == {6'd0, baud_divisor} + 22'd1);
   endproperty
   a_shorten: assert property (p_shorten) // [R11]
      else $error("compensated bit not shortened");

   // Parity follows mask bit 8 alone
   property p_parity;
      @(posedge ref_clk) disable iff (rst)
      (bitReq.load && baudMode == MODE_DIRECT &&
       bitReq.kind == BIT_PARITY && !maskBits[8])
      |-> (tLen == {6'd0, baud_divisor} + 22'd2);
   endproperty
   a_parity: assert property (p_parity) // [R12]
      else $error("parity compensated without mask bit");

   // Start and stop bits are never compensated
   property p_startStop;
      @(posedge ref_clk) disable iff (rst)
      (bitReq.load && baudMode == MODE_DIRECT &&
       (bitReq.kind == BIT_START || bitReq.kind == BIT_STOP))
      |-> (tLen == {6'd0, baud_divisor} + 22'd2);
   endproperty
   a_startStop: assert property (p_startStop) // [R15]
      else $error("start or stop bit compensated");

   // Auto-baud result lands in the divisor field
   property p_abDiv;
      @(posedge ref_clk) disable iff (rst)
      abDone |=> (baud_divisor == $past(abDivisor));
   endproperty
   a_abDiv: assert property (p_abDiv) // [R13]
      else $error("auto-baud divisor not loaded");

   // Auto-baud completion selects mode 2
   property p_abMode;
      @(posedge ref_clk) disable iff (rst)
      abDone |=> (baudMode == MODE_DIRECT);
   endproperty
   a_abMode: assert property (p_abMode) // [R14]
      else $error("auto-baud did not select mode 2");
endmodule
`default_nettype wire

// File: uart_baud_pkg.sv
// Constants and carrier types for the UART baud rate generator.
// Assumes a 32-bit Avalon-MM bus with byte addresses and one clock.
package uart_baud_pkg;
   // Register byte offsets
   localparam logic [3:0]  OFF_BAUD   = 4'h0;
   localparam logic [3:0]  OFF_COMP   = 4'h4;
   localparam logic [3:0]  OFF_FUNC   = 4'h8;
   localparam logic [3:0]  OFF_STAT   = 4'hc;
   // Field positions in the divider and compensation registers
   localparam int          DIV_LSB    = 0;
   localparam int          DIV_W      = 16;
   localparam int          EDIV_LSB   = 24;
   localparam int          EDIV_W     = 4;
   localparam int          MODE_LSB   = 28;
   localparam int          SIGN_BIT   = 31;
   localparam int          MASK_W     = 9;
   localparam int          FUNC_W     = 2;
   localparam int          LEN_W      = 22;
   // Field positions in the status register
   localparam int          ST_IRDA    = 0;
   localparam int          ST_LIMIT   = 1;
   localparam int          ST_BUSY    = 2;
   localparam int          ST_KIND    = 4;
   // Reset values
   localparam logic [31:0] BAUD_RST   = 32'h0000_0000;
   localparam logic [31:0] COMP_RST   = 32'h0000_0000;
   localparam logic [1:0]  FUNC_RST   = 2'h0;
   // Prescale factors and divisor floors
   localparam logic [4:0]  PRESC_X16  = 5'h10;
   localparam logic [4:0]  PRESC_ONE  = 5'h01;
   localparam logic [3:0]  EDIV_MIN   = 4'h8;
   localparam logic [15:0] DIV_MIN_M2 = 16'h0009;
   localparam logic [16:0] DIV_OFFSET = 17'h0_0002;

   // Divider modes, from the two-bit mode field
   typedef enum logic [1:0] {
      MODE_X16    = 2'b00,
      MODE_RSVD   = 2'b01,
      MODE_EXTRA  = 2'b10,
      MODE_DIRECT = 2'b11
   } baudMode_t;

   // Function modes of the controller
   typedef enum logic [1:0] {
      FUNC_UART  = 2'b00,
      FUNC_LIN   = 2'b01,
      FUNC_IRDA  = 2'b10,
      FUNC_RS485 = 2'b11
   } funcMode_t;

   // Kind of bit being timed
   typedef enum logic [3:0] {
      BIT_START = 4'h0, BIT_D0 = 4'h1, BIT_D1 = 4'h2, BIT_D2 = 4'h3,
      BIT_D3 = 4'h4, BIT_D4 = 4'h5, BIT_D5 = 4'h6, BIT_D6 = 4'h7,
      BIT_D7 = 4'h8, BIT_PARITY = 4'h9, BIT_STOP = 4'ha
   } bitKind_t;

   // Avalon-MM request from the master
   typedef struct packed {
      logic        read;
      logic        write;
      logic [3:0]  address;
      logic [31:0] writedata;
      logic [3:0]  byteenable;
   } avReq_t;

   // Request to time one bit
   typedef struct packed {
      logic     load;
      bitKind_t kind;
   } bitReq_t;
endpackage
